// *** hdl/xbar_pkg.sv ***
// Package for the sub-band output crossbar with pulsar gating.
// Assumes one 50 MHz core clock; the double-rate output is a one-cycle
// phase enable from a divider, low part first, high part second.
//
// Summary of operation
// - Per baseband, each of the eighteen board outputs can select any of the eighteen filter outputs.
// - In seven-bit mode, sub-bands whose bandwidth setting exceeds 64 MHz are refused for transport.
// - In seven-bit mode only the seven low bits of each eight-bit filter word travel on.
// - Each seven-bit sample becomes a four-bit low nibble and a three-bit high part at twice the sample rate.
// - In seven-bit mode the top bit of the high-part transfer carries the data-valid flag.
// - Pulsar gating is applied and per-state counts and power of requantized samples are accumulated.
// - One phase-cal extractor per baseband is time-multiplexed over the sub-bands.
// - Identification data is embedded into each outgoing stream.
// - The pulsar timer holds a 32-bit point-slope synthesizer reloadable every 10 ms; the gate generators compare its phase.
// - Several gates, each with its own epoch and duration, follow the pulsar timer.
// - A pulsar timer output is provided to the dump trigger generator.
// - Dump triggers align to the timer epoch and new coefficients take effect on 10 ms time code epochs.
// - An asynchronous, pulled-up external blanking input forces data valid off while asserted.
package xbar_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int N_CH       = 18;
	localparam int SEL_W      = 5;
	localparam int N_GATE     = 4;
	localparam int ID_W       = 16;
	localparam int ID_PERIOD  = 1024;  // Samples between identification words
	localparam int BW_MAX_7B  = 64;    // MHz, seven-bit transport limit
	localparam int EPOCH_MS   = 10;
	localparam int CLK_KHZ    = 50000;
	localparam int EPOCH_CYC  = EPOCH_MS * CLK_KHZ;  // Time code epoch, cycles

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef logic [7:0] word_t;
	typedef struct packed
	{
		logic [31:0] phase;   // Start value
		logic [31:0] slope;   // Increment per cycle
	} synth_coef_s;
	typedef struct packed
	{
		logic [31:0] epoch;   // Timer phase where the gate opens
		logic [31:0] width;   // Open duration in phase units
	} gate_cfg_s;
	typedef struct packed
	{
		logic [3:0] low;      // Low nibble transfer
		logic [3:0] high;     // High part transfer, bit 3 valid in 7-bit mode
	} pair_s;
endpackage

// *** hdl/point_slope_synth.sv ***
// 32-bit point-slope synthesizer with epoch-gated reload.
// Assumes coefficients are held stable by the caller until the epoch.
`timescale 1ns/100ps
module point_slope_synth
	import xbar_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Coefficient load
	input  wire synth_coef_s coef,
	input  wire logic        coef_pend,
	input  wire logic        epoch,
	// Output
	output logic [31:0]      phase,
	output logic             wrap
);
	logic [31:0] acc_q, acc_d;
	logic [31:0] slope_q, slope_d;
	logic        wrap_q, wrap_d;
	logic [32:0] sum;

	// Advance phase; take new point and slope only on an epoch
	always_comb
	begin
		sum     = {1'b0, acc_q} + {1'b0, slope_q};
		acc_d   = sum[31:0];
		slope_d = slope_q;
		wrap_d  = sum[32];
		if (coef_pend && epoch)
		begin
			acc_d   = coef.phase;
			slope_d = coef.slope;
			wrap_d  = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc_q   <= 32'h0;
			slope_q <= 32'h0;
			wrap_q  <= 1'b0;
		end
		else
		begin
			acc_q   <= acc_d;
			slope_q <= slope_d;
			wrap_q  <= wrap_d;
		end
	end

	assign phase = acc_q;
	assign wrap  = wrap_q;
endmodule // point_slope_synth

// *** hdl/subband_crossbar.sv ***
// Output crossbar for one baseband: routing, seven-bit packing,
// gating, statistics, phase-cal, identification and blanking.
// Assumes filter words arrive every other cycle on the sample strobe.
`timescale 1ns/100ps
module subband_crossbar
	import xbar_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Filter side
	input  wire word_t [N_CH-1:0]     fir_data,
	input  wire logic  [N_CH-1:0]     fir_valid,
	input  wire logic  [7:0]          fir_bw_mhz,
	// Configuration
	input  wire logic  [SEL_W-1:0]    route_sel [N_CH],
	input  wire logic                 mode_7bit,
	input  wire logic  [ID_W-1:0]     stream_id,
	input  wire logic  [N_CH-1:0]     gate_map,
	input  wire logic  [1:0]          gate_pick [N_CH],
	// Timing
	input  wire logic                 time_code_epoch,
	input  wire synth_coef_s          timer_coef,
	input  wire logic                 timer_load,
	input  wire gate_cfg_s            gate_cfg [N_GATE],
	input  wire logic                 gate_load,
	// External blanking, asynchronous, low blanks
	input  wire logic                 ext_blank_n,
	// Phase-cal
	input  wire logic  [SEL_W-1:0]    pcal_sel,
	// Outputs toward the recirculation controller
	output pair_s      [N_CH-1:0]     out_pair,
	output logic       [N_CH-1:0]     out_valid,
	output logic                      dump_trigger_stream,
	// Statistics and phase-cal
	output logic       [31:0]         state_count [4],
	output logic       [47:0]         power_acc,
	output logic       [31:0]         pcal_acc,
	output logic       [SEL_W-1:0]    pcal_chan
);
	// ------------------------------------------------------------
	// Blanking synchronizer and rate divider
	// ------------------------------------------------------------
	logic       blk_s1_q, blk_s2_q, phase_q;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			blk_s1_q <= 1'b1;
			blk_s2_q <= 1'b1;
			phase_q  <= 1'b0;
		end
		else
		begin
			blk_s1_q <= ext_blank_n;
			blk_s2_q <= blk_s1_q;
			phase_q  <= ~phase_q;    // Low part on 0, high part on 1
		end
	end
	logic blank;
	assign blank = ~blk_s2_q;

	// ------------------------------------------------------------
	// Pulsar timer, gates, dump trigger
	// ------------------------------------------------------------
	logic        tmr_pend_q, gate_pend_q;
	logic [31:0] tmr_phase;
	logic        tmr_wrap;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tmr_pend_q  <= 1'b0;
			gate_pend_q <= 1'b0;
		end
		else
		begin
			tmr_pend_q  <= timer_load | (tmr_pend_q & ~time_code_epoch);
			gate_pend_q <= gate_load | (gate_pend_q & ~time_code_epoch);
		end
	end

	point_slope_synth u_timer
	(
		.clk       (clk),
		.rst       (rst),
		.coef      (timer_coef),
		.coef_pend (tmr_pend_q),
		.epoch     (time_code_epoch),
		.phase     (tmr_phase),
		.wrap      (tmr_wrap)
	);

	gate_cfg_s  gcfg_q [N_GATE];
	logic [N_GATE-1:0] gate_open;
	always_ff @(posedge clk)
	begin
		if (rst)
			for (int g = 0; g < N_GATE; g++)
				gcfg_q[g] <= '0;
		else if (gate_pend_q && time_code_epoch)
			for (int g = 0; g < N_GATE; g++)
				gcfg_q[g] <= gate_cfg[g];
	end

	// Each gate opens at its epoch relative to the timer phase
	always_comb
	begin
		for (int g = 0; g < N_GATE; g++)
			gate_open[g] = (tmr_phase - gcfg_q[g].epoch) < gcfg_q[g].width;
	end

	logic dump_q;
	always_ff @(posedge clk)
	begin
		if (rst)
			dump_q <= 1'b0;
		else
			dump_q <= tmr_wrap;
	end
	assign dump_trigger_stream = dump_q;

	// ------------------------------------------------------------
	// Routing, identification and packing
	// ------------------------------------------------------------
	logic [9:0]  id_cnt_q;
	logic        id_slot;
	logic        bw_ok;
	assign id_slot = (id_cnt_q < 10'(ID_W / 4));
	assign bw_ok   = ~mode_7bit | (fir_bw_mhz <= 8'(BW_MAX_7B));

	always_ff @(posedge clk)
	begin
		if (rst)
			id_cnt_q <= 10'h0;
		else if (phase_q)
			id_cnt_q <= (id_cnt_q == 10'(ID_PERIOD - 1)) ? 10'h0 : id_cnt_q + 10'h1;
	end

	word_t [N_CH-1:0] sample_q;
	logic  [N_CH-1:0] svalid_q;
	pair_s [N_CH-1:0] pair_q;
	logic  [N_CH-1:0] ov_q;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sample_q <= '0;
			svalid_q <= '0;
			pair_q   <= '0;
			ov_q     <= '0;
		end
		else
			for (int o = 0; o < N_CH; o++)
			begin
				logic v;
				logic [3:0] idn;
				v   = fir_valid[route_sel[o]] & bw_ok & ~blank
				      & (~gate_map[o] | gate_open[gate_pick[o]]);
				idn = stream_id[4*id_cnt_q[1:0] +: 4];
				if (!phase_q)
				begin
					sample_q[o] <= fir_data[route_sel[o]];
					svalid_q[o] <= v;
					pair_q[o].low <= id_slot ? idn : fir_data[route_sel[o]][3:0];
					ov_q[o] <= v & ~id_slot;
				end
				else if (mode_7bit)
					pair_q[o].high <= {svalid_q[o] & ~id_slot & ~blank, sample_q[o][6:4]};
				else
					pair_q[o].high <= sample_q[o][7:4];
			end
	end
	assign out_pair  = pair_q;
	assign out_valid = ov_q & {N_CH{~blank}};

	// ------------------------------------------------------------
	// Requantizer statistics on output 0, phase-cal mux
	// ------------------------------------------------------------
	logic [31:0] cnt_q [4];
	logic [47:0] pw_q;
	logic [31:0] pc_q;
	logic [SEL_W-1:0] pc_ch_q;
	logic [21:0] pc_dwell_q;
	logic signed [6:0] s7;
	assign s7 = sample_q[0][6:0];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int k = 0; k < 4; k++)
				cnt_q[k] <= 32'h0;
			pw_q       <= 48'h0;
			pc_q       <= 32'h0;
			pc_ch_q    <= '0;
			pc_dwell_q <= '0;
		end
		else
		begin
			if (phase_q && svalid_q[0])
			begin
				cnt_q[sample_q[0][6:5]] <= cnt_q[sample_q[0][6:5]] + 32'h1;
				pw_q <= pw_q + 48'(s7 * s7);
			end
			// Phase-cal dwells on one sub-band per epoch, then steps on; a nonzero pcal_sel picks sub-band pcal_sel - 1
			if (time_code_epoch)
			begin
				pc_ch_q <= (pcal_sel != 0) ? pcal_sel - 5'h1 :
				           ((pc_ch_q == 5'(N_CH - 1)) ? 5'h0 : pc_ch_q + 5'h1);
				pc_q    <= 32'h0;
			end
			else if (phase_q && fir_valid[pc_ch_q])
				pc_q <= pc_q + {{24{fir_data[pc_ch_q][7]}}, fir_data[pc_ch_q]} *
				        (tmr_phase[31] ? -32'sh1 : 32'sh1);
		end
	end
	assign state_count = cnt_q;
	assign power_acc   = pw_q;
	assign pcal_acc    = pc_q;
	assign pcal_chan   = pc_ch_q;
endmodule // subband_crossbar

// *** tb/xbar_checker.sv ***
// Port checker for the sub-band crossbar, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module xbar_checker
	import xbar_pkg::*;
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst,
	// Inputs watched
	input wire word_t [N_CH-1:0] fir_data,
	input wire logic [7:0]       fir_bw_mhz,
	input wire logic [SEL_W-1:0] route_sel [N_CH],
	input wire logic             mode_7bit,
	input wire logic             ext_blank_n,
	input wire logic             time_code_epoch,
	input wire logic [SEL_W-1:0] pcal_sel,
	// Outputs watched
	input wire pair_s [N_CH-1:0] out_pair,
	input wire logic [N_CH-1:0]  out_valid,
	input wire logic             dump_trigger_stream,
	input wire logic [31:0]      state_count [4],
	input wire logic [31:0]      pcal_acc,
	input wire logic [SEL_W-1:0] pcal_chan
);
	// ------------------------------------------------------------
	// Sequences and properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Route, data and mode held long enough to refill both halves
	sequence s_held;
		($stable(fir_data) && $stable(route_sel[0]) && $stable(mode_7bit))[*6];
	endsequence
	sequence s_blanked;
		(!ext_blank_n)[*4];
	endsequence
	sequence s_wide7;
		(mode_7bit && fir_bw_mhz > 8'h40)[*4];
	endsequence
	// Reset clears the outputs whatever the reset disable says
	property p_reset_clear;
		disable iff (1'b0) rst |=> (out_valid == '0 && !dump_trigger_stream);
	endproperty
	chk_low_route: assert property (s_held ##0 out_valid[0] |-> out_pair[0].low == fir_data[route_sel[0]][3:0])
		else $error("low nibble differs from routed filter");
	chk_high_route: assert property (s_held ##0 out_valid[0] |-> out_pair[0].high[2:0] == fir_data[route_sel[0]][6:4])
		else $error("high part differs from routed filter");
	chk_mark_valid: assert property ((mode_7bit && !ext_blank_n)[*7] |-> !out_pair[0].high[3])
		else $error("valid mark set while blanked");
	chk_blank_valid: assert property (s_blanked |-> out_valid == '0)
		else $error("valid while external blank held");
	chk_wide_refuse: assert property (s_wide7 |-> out_valid == '0)
		else $error("valid on too wide sub-band in seven-bit mode");
	chk_reset_clear: assert property (p_reset_clear)
		else $error("outputs not cleared by reset");
	chk_dump_single: assert property (dump_trigger_stream |=> !dump_trigger_stream)
		else $error("dump trigger longer than one cycle");
	chk_count_grow: assert property (state_count[0] >= $past(state_count[0]))
		else $error("state count went backwards");
	chk_pcal_range: assert property (pcal_chan < 5'h12)
		else $error("phase-cal channel out of range");
	chk_pcal_clear: assert property (time_code_epoch |=> pcal_acc == 32'h00000000)
		else $error("phase-cal accumulator not cleared on epoch");
	chk_pcal_pick: assert property (time_code_epoch && pcal_sel != 5'h00 |=> pcal_chan == $past(pcal_sel) - 5'h01)
		else $error("phase-cal channel does not follow selection");
endmodule // xbar_checker

bind subband_crossbar xbar_checker u_chk (.clk, .rst, .fir_data, .fir_bw_mhz, .route_sel, .mode_7bit,
	.ext_blank_n, .time_code_epoch, .pcal_sel, .out_pair, .out_valid, .dump_trigger_stream, .state_count,
	.pcal_acc, .pcal_chan);

// *** tb/recirc_rx_model.sv ***
// Receiving controller model: rejoins one output's two halves.
// Assumes the probe is raised once both halves have settled.
`timescale 1ns/100ps
module recirc_rx_model
	import xbar_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// Link and probe
	input  wire pair_s link,
	input  wire logic  probe,
	// Rejoined word
	output word_t      sample,
	output logic       stb
);
	// Rejoin low nibble and high part into one word
	always_ff @(posedge clk)
	begin
		stb <= probe && !rst;
		if (probe)
			sample <= {link.high, link.low};
	end
endmodule // recirc_rx_model

// *** tb/subband_crossbar_pulsar_gate_tb.sv ***
// Self-checking bench for the sub-band crossbar, output 0 watched.
// Assumes the checker is bound and the receiver model is compiled.
`timescale 1ns/100ps
module subband_crossbar_pulsar_gate_tb
	import xbar_pkg::*;
;
	logic             clk = 0, rst = 1, mode_7bit = 1, ext_blank_n = 1, probe = 0;
	logic             time_code_epoch = 0, timer_load = 0, gate_load = 0, dump_trigger_stream, stb;
	word_t [N_CH-1:0] fir_data = '0;
	logic [N_CH-1:0]  fir_valid = '1, gate_map = '0, out_valid;
	logic [7:0]       fir_bw_mhz = 8'h20;
	logic [SEL_W-1:0] route_sel [N_CH], pcal_sel = '0, pcal_chan;
	logic [1:0]       gate_pick [N_CH];
	logic [ID_W-1:0]  stream_id = '0;
	synth_coef_s      timer_coef = '0;
	gate_cfg_s        gate_cfg [N_GATE];
	pair_s [N_CH-1:0] out_pair;
	logic [31:0]      state_count [4], pcal_acc;
	logic [47:0]      power_acc;
	word_t            sample, exp_q [$];
	int               mismatches = 0, tests_run = 0, cyc = 0, dumps = 0;

	subband_crossbar DUT (.clk, .rst, .fir_data, .fir_valid, .fir_bw_mhz, .route_sel, .mode_7bit, .stream_id,
		.gate_map, .gate_pick, .time_code_epoch, .timer_coef, .timer_load, .gate_cfg, .gate_load, .ext_blank_n,
		.pcal_sel, .out_pair, .out_valid, .dump_trigger_stream, .state_count, .power_acc, .pcal_acc, .pcal_chan);
	recirc_rx_model u_rx (.clk, .rst, .link(out_pair[0]), .probe, .sample, .stb);

	// Clock, cycle count since reset and dump pulse count
	initial forever #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= rst ? 0 : cyc + 1;
		dumps <= dumps + int'(dump_trigger_stream);
	end

	task automatic cmp8(input word_t got, input word_t exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One routed sample through output 0; the identification slots are skipped
	task automatic step(input logic m7, input logic [7:0] bw, input logic bl_n);
		int    r;
		int    w;
		word_t d;
		r = $urandom_range(N_CH - 1);
		d = word_t'($urandom);
		@(posedge clk);
		for (int i = 0; i < N_CH; i++)
			fir_data[i] <= (i == r) ? d : word_t'($urandom);
		route_sel[0] <= r[SEL_W-1:0];
		mode_7bit <= m7;
		fir_bw_mhz <= bw;
		ext_blank_n <= bl_n;
		pcal_sel <= SEL_W'($urandom_range(N_CH));
		stream_id <= ID_W'($urandom);
		repeat (10) @(posedge clk);
		w = 0;
		while ((((cyc + 4) % (2 * ID_PERIOD)) < 20) && w < 24)
		begin
			@(posedge clk);
			w++;
		end
		if (w >= 24)
			mismatches++;
		// Gate 0 is configured shut, the other gates wide open
		exp_q.push_back(m7 ? {bl_n && bw <= 8'h40 && (!gate_map[0] || gate_pick[0] != 2'h0), d[6:0]} : d);
		probe <= 1;
		@(posedge clk);
		probe <= 0;
		@(posedge clk);
	endtask

	// Identification nibble k replaces the low part of pair slot k
	task automatic id_step(input int k);
		int              w;
		word_t           d;
		logic [ID_W-1:0] id;
		d  = word_t'($urandom);
		id = ID_W'($urandom);
		@(posedge clk);
		for (int i = 0; i < N_CH; i++)
			fir_data[i] <= d;
		mode_7bit   <= 1'b1;
		fir_bw_mhz  <= 8'h20;
		ext_blank_n <= 1'b1;
		stream_id   <= id;
		repeat (4) @(posedge clk);
		w = 0;
		while (((cyc % (2 * ID_PERIOD)) != 2 * k + 1) && w < 2 * ID_PERIOD + 8)
		begin
			@(posedge clk);
			w++;
		end
		if (w >= 2 * ID_PERIOD + 8)
			mismatches++;
		// Slot carries no valid mark, high part still holds the sample
		exp_q.push_back({1'b0, d[6:4], id[4 * k +: 4]});
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
		@(posedge clk);
	endtask

	// Compare each rejoined word with the oldest expectation
	always @(posedge clk)
	begin
		if (stb && exp_q.size() == 0)
			cmp8(sample, ~sample);
		else if (stb)
			cmp8(sample, exp_q.pop_front());
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h088360D6));
		for (int i = 0; i < N_CH; i++)
		begin
			route_sel[i] = SEL_W'(i);
			gate_pick[i] = 2'($urandom);
		end
		// Gate 0 never opens, gates 1 to 3 stay open at timer phase 0
		for (int g = 0; g < N_GATE; g++)
		begin
			gate_cfg[g].epoch = 32'h00000000;
			gate_cfg[g].width = (g == 0) ? 32'h00000000 : 32'hFFFFFFFF;
		end
		repeat (20) @(posedge clk);
		rst <= 0;
		timer_load <= 1;
		gate_load <= 1;
		@(posedge clk);
		timer_load <= 0;
		gate_load <= 0;
		repeat (20) @(posedge clk);
		cmp8(8'(dumps), 8'h00);
		time_code_epoch <= 1;
		@(posedge clk);
		time_code_epoch <= 0;
		repeat (8) @(posedge clk);
		cmp8(8'(dumps), 8'h01);
		repeat (4) step(1, 8'h20, 1);
		repeat (2) step(0, 8'h20, 1);
		step(1, 8'h40, 1);
		step(1, 8'h41, 1);
		step(1, 8'h20, 0);
		step(1, 8'h20, 1);
		gate_map[0]  <= 1'b1;
		gate_pick[0] <= 2'h0;
		step(1, 8'h20, 1);
		gate_pick[0] <= 2'h1;
		step(1, 8'h20, 1);
		gate_map[0]     <= 1'b0;
		pcal_sel        <= 5'h03;
		time_code_epoch <= 1'b1;
		@(posedge clk);
		time_code_epoch <= 1'b0;
		repeat (2) @(posedge clk);
		cmp8(8'(pcal_chan), 8'h02);
		for (int k = 0; k < 4; k++)
			id_step(k);
		repeat (4) @(posedge clk);
		if (exp_q.size() != 0)
			mismatches++;
		end_sim();
	end
endmodule // subband_crossbar_pulsar_gate_tb
